// ===== verilog/central_request_manager.sv
// Purpose: central request manager, merges 32 channels into two processor requests
// Assumes: channel requests are levels from peripherals on the link
// Notes: registers reached over Avalon-MM, one wait cycle per access
`timescale 1ns/1ns
module central_request_manager
  import request_manager_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  request_link_if.device   link,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  import request_manager_pkg::*;

  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] mask;
    logic [31:0] cls;
    logic        soft_flag;
    logic [7:0]  soft_user;
    logic        fast_req;
    logic        normal_req;
    logic        wake;
    logic [7:0]  fast_vec;
    logic [7:0]  normal_vec;
    logic        wait_req;
    logic [31:0] rdata;
  } state_t;

  typedef enum {
    SEL_ENABLE_MASK,
    SEL_CLASS_SELECT,
    SEL_PENDING,
    SEL_FAST_VECTOR,
    SEL_NORMAL_VECTOR,
    SEL_MODE_VECTOR,
    SEL_SOFT_KEY,
    SEL_SOFT_FLAG,
    SEL_UNMAPPED
  } reg_sel_t;

  state_t st;
  state_t next_st;

  // scan from the top so the lowest set channel plus one is left in r
  function automatic logic [7:0] lowest_plus_one(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i + 1);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one address decode shared by the read and the write path
  function automatic reg_sel_t decode_reg(input logic [2:0] word_addr);
    reg_sel_t s;
    case ({word_addr, 2'b00})
      ENABLE_MASK_OFF:   s = SEL_ENABLE_MASK;
      CLASS_SELECT_OFF:  s = SEL_CLASS_SELECT;
      PENDING_OFF:       s = SEL_PENDING;
      FAST_VECTOR_OFF:   s = SEL_FAST_VECTOR;
      NORMAL_VECTOR_OFF: s = SEL_NORMAL_VECTOR;
      MODE_VECTOR_OFF:   s = SEL_MODE_VECTOR;
      SOFT_KEY_OFF:      s = SEL_SOFT_KEY;
      SOFT_FLAG_OFF:     s = SEL_SOFT_FLAG;
      default:           s = SEL_UNMAPPED;
    endcase
    return s;
  endfunction

  // narrow registers sit in the low bits, the rest reads zero
  function automatic logic [31:0] read_word(input reg_sel_t    s,
                                            input state_t      cur,
                                            input logic [31:0] pend,
                                            input logic        fast);
    logic [31:0] w;
    case (s)
      SEL_ENABLE_MASK:   w = cur.mask;
      SEL_CLASS_SELECT:  w = cur.cls;
      SEL_PENDING:       w = pend;
      SEL_FAST_VECTOR:   w = {24'h00_0000, cur.fast_vec};
      SEL_NORMAL_VECTOR: w = {24'h00_0000, cur.normal_vec};
      SEL_MODE_VECTOR:   w = {24'h00_0000, fast ? cur.fast_vec : cur.normal_vec};
      SEL_SOFT_KEY:      w = {24'h00_0000, cur.soft_user};
      SEL_SOFT_FLAG:     w = {31'h0, cur.soft_flag};
      default:           w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  logic [31:0] active;
  logic [31:0] enabled;
  logic [31:0] fast_set;
  logic [31:0] normal_set;
  logic [31:0] soft_bit;
  reg_sel_t    sel;
  logic        take;
  logic        key_hit;
  logic        soft_set;

  always_comb begin
    next_st    = st;
    sel        = decode_reg(avs_address_i);
    soft_bit   = 32'h0000_0000;
    soft_bit[SOFT_CHANNEL] = st.soft_flag;
    active     = st.sync2 | soft_bit;
    enabled    = active & st.mask;
    fast_set   = enabled & st.cls;
    normal_set = enabled & ~st.cls;
    take       = (avs_read_i | avs_write_i) & ~st.wait_req;
    key_hit    = avs_byteenable_i[1] && (avs_writedata_i[15:8] == SOFT_KEY);
    soft_set   = 1'b0;

    // two flops per channel against setup violations
    next_st.sync1 = link.chan_req;
    next_st.sync2 = st.sync1;

    // per-class merge, lowest channel first
    next_st.fast_req   = |fast_set;
    next_st.normal_req = |normal_set;
    // wake ignores the enable mask
    next_st.wake       = link.low_power & (|active);
    next_st.fast_vec   = lowest_plus_one(fast_set);
    next_st.normal_vec = lowest_plus_one(normal_set);

    // answer one cycle after the request is seen
    if ((avs_read_i | avs_write_i) & st.wait_req) begin
      next_st.wait_req = 1'b0;
      next_st.rdata    = read_word(sel, st, active, link.fast_mode);
    end
    if (take) begin
      next_st.wait_req = 1'b1;
    end

    // writes land at the edge that ends the transfer
    if (take & avs_write_i) begin
      case (sel)
        SEL_ENABLE_MASK: begin
          next_st.mask = lane_merge(st.mask, avs_writedata_i, avs_byteenable_i);
        end
        SEL_CLASS_SELECT: begin
          next_st.cls = lane_merge(st.cls, avs_writedata_i, avs_byteenable_i);
        end
        SEL_SOFT_KEY: begin
          if (avs_byteenable_i[0]) begin
            next_st.soft_user = avs_writedata_i[7:0];
          end
          if (key_hit) begin
            soft_set = 1'b1;
          end
        end
        SEL_SOFT_FLAG: begin
          if (avs_byteenable_i[0] && !avs_writedata_i[0]) begin
            next_st.soft_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (soft_set) begin
      next_st.soft_flag = 1'b1;
    end
  end

  // every register of the block updates here
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st           <= '0;
      st.mask      <= ENABLE_MASK_RST;
      st.cls       <= CLASS_SELECT_RST;
      st.soft_user <= SOFT_USER_RST;
      st.wait_req  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from the state register
  assign link.fast_req     = st.fast_req;
  assign link.normal_req   = st.normal_req;
  assign link.wake         = st.wake;
  assign avs_readdata_o    = st.rdata;
  assign avs_waitrequest_o = st.wait_req;
endmodule // central_request_manager

// ===== verilog/request_manager_pkg.sv
// Purpose: constants shared by the request manager and its processor-side end
// Assumes: one 20 MHz clock, Avalon-MM register port with waitrequest
// Notes: register offsets are byte addresses of aligned 32-bit words
// Overview of operation
// - thirty-two hardwired peripheral request channels
// - each request synchronized, sampled every clock
// - channels merge into fast and normal outputs
// - per-channel enable mask gates both outputs
// - class-select bit routes channel fast or normal
// - low power wake-up ignores the channel mask
// - lowest-numbered active enabled channel wins per class
// - fast and normal requests may assert together
// - read-only eight-bit vector offset per class
// - combined offset follows processor fast mode
// - pending register shows all channels at once
// - key 0x75 sets soft flag, raises request
// - soft request holds until software clears flag
// - low byte of soft register holds user value
// - processor serves fast before normal, may preempt
// - class accepted only when status mask bit clear
// - accepting sets bit 7, fast sets 6 and 7
// - vector fetch 0x0018 normal, 0x001C fast
// - peripheral requests only when flag and enable set
package request_manager_pkg;
  localparam int          CHANNELS          = 32;
  localparam logic [4:0]  SOFT_CHANNEL      = 5'h1F;
  localparam logic [7:0]  SOFT_KEY          = 8'h75;
  localparam logic [4:0]  ENABLE_MASK_OFF   = 5'h00;
  localparam logic [4:0]  CLASS_SELECT_OFF  = 5'h04;
  localparam logic [4:0]  PENDING_OFF       = 5'h08;
  localparam logic [4:0]  FAST_VECTOR_OFF   = 5'h0C;
  localparam logic [4:0]  NORMAL_VECTOR_OFF = 5'h10;
  localparam logic [4:0]  MODE_VECTOR_OFF   = 5'h14;
  localparam logic [4:0]  SOFT_KEY_OFF      = 5'h18;
  localparam logic [4:0]  SOFT_FLAG_OFF     = 5'h1C;
  localparam logic [31:0] ENABLE_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] CLASS_SELECT_RST  = 32'h0000_0000;
  localparam logic [7:0]  SOFT_USER_RST     = 8'h00;
  localparam logic [7:0]  STATUS_RST        = 8'hC0;
  localparam int          FAST_MASK_BIT     = 6;
  localparam int          NORMAL_MASK_BIT   = 7;
  localparam logic [15:0] NORMAL_VECTOR     = 16'h0018;
  localparam logic [15:0] FAST_VECTOR       = 16'h001C;
endpackage

// ===== verilog/request_link_if.sv
`timescale 1ns/1ns
interface request_link_if;
  logic [31:0] chan_req;
  logic        fast_req;
  logic        normal_req;
  logic        fast_mode;
  logic        low_power;
  logic        wake;
  modport device (input chan_req, input fast_mode, input low_power,
                  output fast_req, output normal_req, output wake);
  modport host (output chan_req, output fast_mode, output low_power,
                input fast_req, input normal_req, input wake);
endinterface

// ===== verilog/processor_request_end.sv
// Purpose: processor and peripheral side of the request link
// Assumes: user side supplies peripheral events and status word writes
// Notes: acceptance beats a status write in the same cycle
`timescale 1ns/1ns
module processor_request_end
  import request_manager_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  request_link_if.host     link,
  input  wire logic [31:0] event_set_i,
  input  wire logic [31:0] event_clear_i,
  input  wire logic [31:0] event_enable_i,
  input  wire logic        low_power_i,
  input  wire logic        status_write_i,
  input  wire logic [7:0]  status_wdata_i,
  output logic      [31:0] event_flag_o,
  output logic      [7:0]  cpu_status_word_o,
  output logic      [15:0] vector_addr_o,
  output logic             accept_o,
  output logic             fast_mode_o
);
  import request_manager_pkg::*;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] req;
    logic [7:0]  status;
    logic [15:0] vector;
    logic        accept;
    logic        fast_mode;
    logic        low_power;
  } state_t;

  state_t st;
  state_t next_st;

  always_comb begin
    next_st           = st;
    next_st.flags     = (st.flags & ~event_clear_i) | event_set_i;
    next_st.req       = st.flags & event_enable_i;
    next_st.low_power = low_power_i;
    next_st.accept    = 1'b0;
    if (status_write_i) begin
      next_st.status = status_wdata_i;
      if (status_wdata_i[FAST_MASK_BIT]) begin
        next_st.fast_mode = st.fast_mode;
      end else begin
        next_st.fast_mode = 1'b0;
      end
    end
    if (link.fast_req && !st.status[FAST_MASK_BIT]) begin
      next_st.status                  = st.status;
      next_st.status[FAST_MASK_BIT]   = 1'b1;
      next_st.status[NORMAL_MASK_BIT] = 1'b1;
      next_st.vector                  = FAST_VECTOR;
      next_st.fast_mode               = 1'b1;
      next_st.accept                  = 1'b1;
    end else if (link.normal_req && !st.status[NORMAL_MASK_BIT]) begin
      next_st.status                  = st.status;
      next_st.status[NORMAL_MASK_BIT] = 1'b1;
      next_st.vector                  = NORMAL_VECTOR;
      next_st.fast_mode               = 1'b0;
      next_st.accept                  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st        <= '0;
      st.status <= STATUS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign link.chan_req     = st.req;
  assign link.fast_mode    = st.fast_mode;
  assign link.low_power    = st.low_power;
  assign event_flag_o      = st.flags;
  assign cpu_status_word_o = st.status;
  assign vector_addr_o     = st.vector;
  assign accept_o          = st.accept;
  assign fast_mode_o       = st.fast_mode;
endmodule // processor_request_end

// ===== sim/request_link_properties.sv
// Purpose: link checks for the request manager pair
// Assumes: one clock, asynchronous active-low reset
// Notes: sees the link signals plus the accept strobe and the status word
`timescale 1ns/1ns
module request_link_properties (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic [31:0] chan_req,
  input  wire logic        fast_req,
  input  wire logic        normal_req,
  input  wire logic        fast_mode,
  input  wire logic        low_power,
  input  wire logic        wake,
  input  wire logic        accept,
  input  wire logic [7:0]  cpu_status_word
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  property p_wake_gate;
    !low_power |=> !wake;
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake outside low power");
  property p_wake_bypass;
    (low_power && chan_req[30:0] != 31'h0 && $stable(chan_req))[*4] |-> wake;
  endproperty
  a_wake_bypass: assert property (p_wake_bypass)
    else $error("wake missing for active channel");
  property p_fast_mode_cause;
    $rose(fast_mode) |-> $past(fast_req);
  endproperty
  a_fast_mode_cause: assert property (p_fast_mode_cause)
    else $error("fast mode without fast request");
  property p_reset_quiet;
    $rose(rstn_i) |-> !fast_req && !normal_req && !wake;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("requests active after reset");
  property p_host_idle;
    $rose(rstn_i) |-> chan_req == 32'h0 && !fast_mode;
  endproperty
  a_host_idle: assert property (p_host_idle)
    else $error("host link busy after reset");
  property p_accept_masks;
    accept |-> cpu_status_word[7] && (cpu_status_word[6] || !fast_mode);
  endproperty
  a_accept_masks: assert property (p_accept_masks)
    else $error("accepted request left status unmasked");
  property p_fast_accept_open;
    accept && fast_mode |-> !$past(cpu_status_word[6]);
  endproperty
  a_fast_accept_open: assert property (p_fast_accept_open)
    else $error("fast request accepted while masked");
  c_both: cover property (fast_req && normal_req);
endmodule // request_link_properties

// ===== sim/central_request_manager_tb.sv
// Purpose: self-checking bench for the request manager pair
// Assumes: 20 MHz clock, Avalon-MM register port
// Notes: both ends face each other across the link
`timescale 1ns/1ns
module central_request_manager_tb;
  logic        mclk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        low_power_i, status_write_i, accept_o, fast_mode_o;
  logic [2:0]  avs_address_i;
  logic [3:0]  avs_byteenable_i;
  logic [7:0]  status_wdata_i, cpu_status_word_o;
  logic [15:0] vector_addr_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, event_flag_o;
  logic [31:0] event_set_i, event_clear_i, event_enable_i;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  request_link_if link ();
  central_request_manager u_central_request_manager (.mclk_i, .rstn_i, .link(link),
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o);
  processor_request_end u_processor_request_end (.mclk_i, .rstn_i, .link(link),
    .event_set_i, .event_clear_i, .event_enable_i, .low_power_i, .status_write_i,
    .status_wdata_i, .event_flag_o, .cpu_status_word_o, .vector_addr_o, .accept_o,
    .fast_mode_o);
  request_link_properties u_request_link_properties (.mclk_i, .rstn_i,
    .chan_req(link.chan_req), .fast_req(link.fast_req), .normal_req(link.normal_req),
    .fast_mode(link.fast_mode), .low_power(link.low_power), .wake(link.wake),
    .accept(accept_o), .cpu_status_word(cpu_status_word_o));
  always #25 mclk_i = ~mclk_i;
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail_if(input logic c);
    if (c) begin
      n_mismatch++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    fail_if(avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ev(input logic [31:0] s, input logic [31:0] c);
    @(posedge mclk_i);
    event_set_i <= s;
    event_clear_i <= c;
    @(posedge mclk_i);
    event_set_i <= 32'h0;
    event_clear_i <= 32'h0;
  endtask
  task automatic status(input logic [7:0] v);
    int n;
    n = 0;
    @(posedge mclk_i);
    status_write_i <= 1'b1;
    status_wdata_i <= v;
    @(posedge mclk_i);
    status_write_i <= 1'b0;
    while (accept_o !== 1'b1 && n < 16) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    fail_if(accept_o !== 1'b1);
  endtask
  initial begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    {avs_read_i, avs_write_i, low_power_i, status_write_i} = 4'h0;
    avs_address_i = 3'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    status_wdata_i = 8'h0;
    {event_set_i, event_clear_i} = 64'h0;
    event_enable_i = 32'hFFFF_FFFF;
    cyc(8);
    rstn_i <= 1'b1;
    for (int a = 0; a < 8; a++) rchk(3'(a), 32'h0);
    ev(32'h208, 32'h0);
    bus(1'b1, 3'h0, 32'h200);
    cyc(6);
    rchk(3'h4, 32'hA);
    rchk(3'h2, 32'h208);
    rchk(3'h3, 32'h0);
    bus(1'b1, 3'h0, 32'h8000_0208);
    bus(1'b1, 3'h1, 32'h8);
    bus(1'b1, 3'h3, 32'hFF);
    cyc(6);
    rchk(3'h3, 32'h4);
    rchk(3'h4, 32'hA);
    chk(32'({link.fast_req, link.normal_req}), 32'h3);
    rchk(3'h5, 32'hA);
    status(8'h00);
    chk({16'h0, vector_addr_o}, 32'h1C);
    chk({23'h0, fast_mode_o, cpu_status_word_o}, 32'h1C0);
    rchk(3'h5, 32'h4);
    status(8'h40);
    chk({16'h0, vector_addr_o}, 32'h18);
    chk({23'h0, fast_mode_o, cpu_status_word_o}, 32'hC0);
    rchk(3'h5, 32'hA);
    ev(32'h0, 32'hFFFF_FFFF);
    bus(1'b1, 3'h6, 32'h1234);
    rchk(3'h6, 32'h34);
    rchk(3'h7, 32'h0);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, 3'h6, 32'h7556);
    rchk(3'h6, 32'h56);
    rchk(3'h7, 32'h0);
    avs_byteenable_i <= 4'hF;
    bus(1'b1, 3'h6, 32'h7534);
    rchk(3'h7, 32'h1);
    rchk(3'h2, 32'h8000_0000);
    cyc(3);
    rchk(3'h4, 32'h20);
    bus(1'b1, 3'h0, 32'h208);
    cyc(2);
    chk(32'(link.normal_req), 32'h0);
    rchk(3'h2, 32'h8000_0000);
    bus(1'b1, 3'h7, 32'h0);
    rchk(3'h7, 32'h0);
    low_power_i <= 1'b1;
    ev(32'h20, 32'h0);
    for (int n = 0; n < 16 && link.wake !== 1'b1; n++) cyc(1);
    #1;
    chk(32'(link.wake), 32'h1);
    chk(32'(link.normal_req), 32'h0);
    chk(event_flag_o, 32'h20);
    cyc(4);
    event_enable_i <= 32'hFFFF_FFDF;
    cyc(5);
    rchk(3'h2, 32'h0);
    chk(event_flag_o, 32'h20);
    rstn_i <= 1'b0;
    cyc(2);
    rstn_i <= 1'b1;
    rchk(3'h0, 32'h0);
    rchk(3'h6, 32'h0);
    chk({24'h0, cpu_status_word_o}, 32'hC0);
    chk(event_flag_o, 32'h0);
    give_verdict();
  end
endmodule // central_request_manager_tb
